// >>> verilog/afc_pkg.sv
/*
  Constants for the alarm frame capture block: register map, field
  positions, reset values and frame geometry.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package afc_pkg;

  // ---------------------------------------------------------------
  // Frame geometry
  // ---------------------------------------------------------------
  localparam int unsigned FRAME_BYTES = 48;
  localparam int unsigned FRAME_WORDS = 12;
  localparam int unsigned NUM_DIRS    = 2;
  localparam int unsigned DIR_CMD     = 0;
  localparam int unsigned DIR_RSP     = 1;
  localparam logic [5:0]  LAST_BYTE   = 6'h2F;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL        = 12'h000;
  localparam logic [11:0] OFS_STATUS      = 12'h004;
  localparam logic [11:0] OFS_REGEN_WARN  = 12'h008;
  localparam logic [11:0] OFS_REGEN_ALARM = 12'h00C;
  localparam logic [11:0] OFS_DB_WARN     = 12'h010;
  localparam logic [11:0] OFS_DB_ALARM    = 12'h014;
  localparam logic [11:0] OFS_CMD_CAP     = 12'h040;
  localparam logic [11:0] OFS_RSP_CAP     = 12'h080;
  localparam logic [11:0] CAP_SPAN_MASK   = 12'hFC0;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_CLEAR_BIT  = 0;
  localparam int unsigned ST_REGEN_WARN   = 0;
  localparam int unsigned ST_REGEN_ALARM  = 1;
  localparam int unsigned ST_DB_WARN      = 2;
  localparam int unsigned ST_DB_ALARM     = 3;
  localparam int unsigned ST_OT_WARN      = 4;
  localparam int unsigned ST_COUNT_LSB    = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_REGEN_WARN  = 16'hC000;
  localparam logic [15:0] RST_REGEN_ALARM = 16'hFFFF;
  localparam logic [15:0] RST_DB_WARN     = 16'hC000;
  localparam logic [15:0] RST_DB_ALARM    = 16'hFFFF;
  localparam logic [31:0] RST_WORD        = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Bus responses
  // ---------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage

// >>> verilog/afc_capture.sv
/*
  Alarm frame capture: assembles incoming command and outgoing response
  frames byte by byte, freezes both on any alarm or warning, and raises
  regeneration, dynamic brake and overtravel warnings.
  Assumes frame bytes, load levels and alarm inputs come from logic on
  aclk; overtravel pins are asynchronous. Registers sit on AXI4-Lite.
*/
`timescale 1ns/10ps
`default_nettype none

module afc_capture
  import afc_pkg::*;
#(
  parameter int unsigned ADDR_W  = 12,
  parameter int unsigned LEVEL_W = 16
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               cmd_byte_valid,
  input  wire logic               cmd_frame_start,
  input  wire logic [7:0]         cmd_byte,
  input  wire logic               rsp_byte_valid,
  input  wire logic               rsp_frame_start,
  input  wire logic [7:0]         rsp_byte,
  input  wire logic               alarm_in,
  input  wire logic               param_warning_in,
  input  wire logic               command_warning_in,
  input  wire logic               servo_on,
  input  wire logic               pos_overtravel_pin,
  input  wire logic               neg_overtravel_pin,
  input  wire logic [LEVEL_W-1:0] regen_level,
  input  wire logic [LEVEL_W-1:0] dynamic_brake_level,
  output logic                    regen_warning,
  output logic                    regen_alarm,
  output logic                    dynamic_brake_warning,
  output logic                    dynamic_brake_alarm,
  output logic                    overtravel_warning,
  output logic                    capture_event
);
  import afc_pkg::*;

  initial begin
    if (ADDR_W < 8 || ADDR_W > 32) $error("afc_capture: ADDR_W must be 8..32");
    if (LEVEL_W < 1 || LEVEL_W > 16) $error("afc_capture: LEVEL_W must be 1..16");
  end

  // ---------------------------------------------------------------
  // Frame byte inputs per direction
  // ---------------------------------------------------------------
  logic        byte_vld  [NUM_DIRS];
  logic        byte_sof  [NUM_DIRS];
  logic [7:0]  byte_dat  [NUM_DIRS];
  logic [5:0]  byte_cnt  [NUM_DIRS];
  logic        frame_end [NUM_DIRS];
  logic [31:0] work_w    [NUM_DIRS][FRAME_WORDS];
  logic [31:0] last_w    [NUM_DIRS][FRAME_WORDS];
  logic [31:0] cap_w     [NUM_DIRS][FRAME_WORDS];

  assign byte_vld[DIR_CMD] = cmd_byte_valid;
  assign byte_sof[DIR_CMD] = cmd_frame_start;
  assign byte_dat[DIR_CMD] = cmd_byte;
  assign byte_vld[DIR_RSP] = rsp_byte_valid;
  assign byte_sof[DIR_RSP] = rsp_frame_start;
  assign byte_dat[DIR_RSP] = rsp_byte;

  // ---------------------------------------------------------------
  // Register file state
  // ---------------------------------------------------------------
  logic [15:0] regen_warn_lim;
  logic [15:0] regen_alarm_lim;
  logic [15:0] db_warn_lim;
  logic [15:0] db_alarm_lim;
  logic [7:0]  capture_count;
  logic        clear_flags;
  logic        aw_full;
  logic        w_full;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        wr_hit;
  logic [31:0] next_rdata;
  logic        rd_hit;

  // ---------------------------------------------------------------
  // Frame assembly and capture
  // ---------------------------------------------------------------
  generate
    for (genvar d = 0; d < NUM_DIRS; d++) begin : g_dir
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          byte_cnt[d]  <= 6'h00;
          frame_end[d] <= 1'b0;
        end else begin
          frame_end[d] <= 1'b0;
          if (byte_vld[d] && byte_sof[d]) begin
            byte_cnt[d] <= 6'h01;
          end else if (byte_vld[d] && byte_cnt[d] <= LAST_BYTE) begin
            byte_cnt[d]  <= byte_cnt[d] + 6'h01;
            frame_end[d] <= (byte_cnt[d] == LAST_BYTE);
          end
        end
      end
    end
  endgenerate

  // Byte lanes: index bits 5:2 pick the word, bits 1:0 the lane
  always_ff @(posedge aclk) begin
    for (int d = 0; d < NUM_DIRS; d++) begin
      if (!aresetn) begin
        for (int i = 0; i < FRAME_WORDS; i++) begin
          work_w[d][i] <= RST_WORD;
        end
      end else if (byte_vld[d] && byte_sof[d]) begin
        work_w[d][0][7:0] <= byte_dat[d];
      end else if (byte_vld[d] && byte_cnt[d] <= LAST_BYTE) begin
        work_w[d][byte_cnt[d][5:2]][{byte_cnt[d][1:0], 3'b000} +: 8] <= byte_dat[d];
      end
    end
  end

  // Only whole frames become the frame that a capture freezes
  always_ff @(posedge aclk) begin
    for (int d = 0; d < NUM_DIRS; d++) begin
      for (int i = 0; i < FRAME_WORDS; i++) begin
        if (!aresetn) begin
          last_w[d][i] <= RST_WORD;
        end else if (frame_end[d]) begin
          last_w[d][i] <= work_w[d][i];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    for (int d = 0; d < NUM_DIRS; d++) begin
      for (int i = 0; i < FRAME_WORDS; i++) begin
        if (!aresetn) begin
          cap_w[d][i] <= RST_WORD;
        end else if (capture_event) begin
          cap_w[d][i] <= last_w[d][i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Overtravel pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pot_sync;
  logic [2:0] not_sync;
  logic       pot_state;
  logic       not_state;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pot_sync  <= 3'h0;
      not_sync  <= 3'h0;
      pot_state <= 1'b0;
      not_state <= 1'b0;
    end else begin
      pot_sync <= {pot_sync[1:0], pos_overtravel_pin};
      not_sync <= {not_sync[1:0], neg_overtravel_pin};
      if (pot_sync[1] == pot_sync[2]) begin
        pot_state <= pot_sync[2];
      end
      if (not_sync[1] == not_sync[2]) begin
        not_state <= not_sync[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // Warning and alarm flags
  // ---------------------------------------------------------------
  logic set_regen_warn;
  logic set_regen_alarm;
  logic set_db_warn;
  logic set_db_alarm;
  logic set_ot_warn;
  logic ext_prev;
  logic ext_rise;
  logic [2:0] ext_now;
  logic [2:0] ext_last;

  assign set_regen_warn  = 16'(regen_level) >= regen_warn_lim;
  assign set_regen_alarm = 16'(regen_level) >= regen_alarm_lim && regen_warning;
  assign set_db_warn     = 16'(dynamic_brake_level) >= db_warn_lim;
  assign set_db_alarm    = 16'(dynamic_brake_level) >= db_alarm_lim
                           && dynamic_brake_warning;
  assign set_ot_warn     = (pot_state || not_state) && servo_on;
  assign ext_now         = {alarm_in, param_warning_in, command_warning_in};
  assign ext_rise        = |(ext_now & ~ext_last);
  assign ext_prev        = |ext_last;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regen_warning         <= 1'b0;
      regen_alarm           <= 1'b0;
      dynamic_brake_warning <= 1'b0;
      dynamic_brake_alarm   <= 1'b0;
      overtravel_warning    <= 1'b0;
    end else begin
      regen_warning         <= set_regen_warn || (regen_warning && !clear_flags);
      regen_alarm           <= set_regen_alarm || (regen_alarm && !clear_flags);
      dynamic_brake_warning <= set_db_warn || (dynamic_brake_warning && !clear_flags);
      dynamic_brake_alarm   <= set_db_alarm || (dynamic_brake_alarm && !clear_flags);
      overtravel_warning    <= set_ot_warn || (overtravel_warning && !clear_flags);
    end
  end

  // One capture per cycle in which any alarm or warning is newly raised
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_last      <= 3'h0;
      capture_event <= 1'b0;
      capture_count <= 8'h00;
    end else begin
      ext_last      <= ext_now;
      capture_event <= ext_rise
                       || (set_regen_warn && !regen_warning)
                       || (set_regen_alarm && !regen_alarm)
                       || (set_db_warn && !dynamic_brake_warning)
                       || (set_db_alarm && !dynamic_brake_alarm)
                       || (set_ot_warn && !overtravel_warning);
      if (capture_event) begin
        capture_count <= capture_count + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  assign do_write = aw_full && w_full && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_full       <= 1'b0;
      aw_addr       <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_full       <= 1'b1;
      aw_addr       <= 12'(s_axi_awaddr);
    end else if (do_write) begin
      aw_full <= 1'b0;
    end else if (!aw_full && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_full       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_full       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else if (do_write) begin
      w_full <= 1'b0;
    end else if (!w_full && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_comb begin
    unique case (aw_addr)
      OFS_CTRL, OFS_STATUS, OFS_REGEN_WARN,
      OFS_REGEN_ALARM, OFS_DB_WARN, OFS_DB_ALARM: wr_hit = 1'b1;
      default:                                    wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regen_warn_lim  <= RST_REGEN_WARN;
      regen_alarm_lim <= RST_REGEN_ALARM;
      db_warn_lim     <= RST_DB_WARN;
      db_alarm_lim    <= RST_DB_ALARM;
      clear_flags     <= 1'b0;
    end else begin
      clear_flags <= do_write && aw_addr == OFS_CTRL && w_strb[0]
                     && w_data[CTRL_CLEAR_BIT];
      for (int b = 0; b < 2; b++) begin
        if (do_write && w_strb[b]) begin
          if (aw_addr == OFS_REGEN_WARN)  regen_warn_lim[b*8 +: 8]  <= w_data[b*8 +: 8];
          if (aw_addr == OFS_REGEN_ALARM) regen_alarm_lim[b*8 +: 8] <= w_data[b*8 +: 8];
          if (aw_addr == OFS_DB_WARN)     db_warn_lim[b*8 +: 8]     <= w_data[b*8 +: 8];
          if (aw_addr == OFS_DB_ALARM)    db_alarm_lim[b*8 +: 8]    <= w_data[b*8 +: 8];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  always_comb begin
    logic [11:0] ra;
    ra         = 12'(s_axi_araddr);
    next_rdata = 32'h0000_0000;
    rd_hit     = 1'b1;
    if ((ra & CAP_SPAN_MASK) == OFS_CMD_CAP && ra[5:2] < 4'(FRAME_WORDS) && ra[1:0] == 2'b00) begin
      next_rdata = cap_w[DIR_CMD][ra[5:2]];
    end else if ((ra & CAP_SPAN_MASK) == OFS_RSP_CAP && ra[5:2] < 4'(FRAME_WORDS)
                 && ra[1:0] == 2'b00) begin
      next_rdata = cap_w[DIR_RSP][ra[5:2]];
    end else if (ra == OFS_CTRL) begin
      next_rdata = 32'h0000_0000;
    end else if (ra == OFS_STATUS) begin
      next_rdata[ST_REGEN_WARN]  = regen_warning;
      next_rdata[ST_REGEN_ALARM] = regen_alarm;
      next_rdata[ST_DB_WARN]     = dynamic_brake_warning;
      next_rdata[ST_DB_ALARM]    = dynamic_brake_alarm;
      next_rdata[ST_OT_WARN]     = overtravel_warning;
      next_rdata[ST_COUNT_LSB +: 8] = capture_count;
    end else if (ra == OFS_REGEN_WARN) begin
      next_rdata[15:0] = regen_warn_lim;
    end else if (ra == OFS_REGEN_ALARM) begin
      next_rdata[15:0] = regen_alarm_lim;
    end else if (ra == OFS_DB_WARN) begin
      next_rdata[15:0] = db_warn_lim;
    end else if (ra == OFS_DB_ALARM) begin
      next_rdata[15:0] = db_alarm_lim;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_CAP_CMD: assert property (@(posedge aclk) disable iff (!aresetn)
    capture_event |=> cap_w[DIR_CMD][11] == $past(last_w[DIR_CMD][11])
                      && cap_w[DIR_CMD][0] == $past(last_w[DIR_CMD][0]))
    else $error("Command capture did not take the last frame");

  AST_CAP_RSP: assert property (@(posedge aclk) disable iff (!aresetn)
    capture_event |=> cap_w[DIR_RSP][6] == $past(last_w[DIR_RSP][6]))
    else $error("Response capture did not take the last frame");

  AST_LANE_TOP: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_byte_valid && !cmd_frame_start && byte_cnt[DIR_CMD] == 6'h03)
    |=> work_w[DIR_CMD][0][31:24] == $past(cmd_byte))
    else $error("Fourth byte not in bits 31:24");

  AST_WORD_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
    (rsp_byte_valid && !rsp_frame_start && byte_cnt[DIR_RSP] == 6'h08)
    |=> work_w[DIR_RSP][2][7:0] == $past(rsp_byte))
    else $error("Byte 8 not in low lane of third word");

  AST_WARN_TRIG: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(param_warning_in) || $rose(command_warning_in) |=> capture_event ##1
    capture_count == $past(capture_count, 2) + 8'h01)
    else $error("Warning input did not trigger a capture");

  AST_REGEN_ORDER: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(regen_alarm) |-> $past(regen_warning))
    else $error("Regeneration alarm without prior warning");

  AST_DB_ORDER: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(dynamic_brake_alarm) |-> $past(dynamic_brake_warning))
    else $error("Dynamic brake alarm without prior warning");

  AST_OT_WARN: assert property (@(posedge aclk) disable iff (!aresetn)
    set_ot_warn |=> overtravel_warning ##1 (overtravel_warning || $past(clear_flags)))
    else $error("Overtravel warning not raised");

  AST_OT_MOMENT: assert property (@(posedge aclk) disable iff (!aresetn)
    set_ot_warn |=> overtravel_warning)
    else $error("Momentary overtravel lost");

  AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    !capture_event |=> $stable(cap_w[DIR_CMD][5]) && $stable(cap_w[DIR_RSP][5]))
    else $error("Captured words changed without an event");

endmodule

`default_nettype wire

// >>> testbench/afc_host_model.sv
/*
  Host controller model: sends one 48-byte command frame per go pulse.
  Assumes go is a one-cycle pulse on aclk while busy is low.
*/
`timescale 1ns/10ps
`default_nettype none
module afc_host_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       go,
  input  wire logic [7:0] base,
  output logic            cmd_byte_valid,
  output logic            cmd_frame_start,
  output logic [7:0]      cmd_byte,
  output logic            busy
);
  logic [5:0] idx;
  // ---------------------------------------------------------------
  // Byte sender; between frames the byte lines invert on every cycle
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy            <= 1'b0;
      idx             <= 6'h00;
      cmd_byte_valid  <= 1'b0;
      cmd_frame_start <= 1'b0;
      cmd_byte        <= 8'h00;
    end else if (go || busy) begin
      cmd_byte_valid  <= 1'b1;
      cmd_frame_start <= go;
      cmd_byte        <= base + {2'b00, idx};
      idx             <= (idx == 6'h2F) ? 6'h00 : idx + 6'h01;
      busy            <= (idx != 6'h2F);
    end else begin
      cmd_byte_valid  <= 1'b0;
      cmd_frame_start <= 1'b0;
      cmd_byte        <= ~cmd_byte;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb_alarm_frame_capture.sv
/*
  Testbench for afc_capture: AXI4-Lite register access, frame capture,
  overload and overtravel warnings. Assumes the host model beside it.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_alarm_frame_capture;
  import afc_pkg::*;
  logic        aclk, aresetn, awv, wv, bre, arv, rre, go, hv, hs, busy;
  logic        rv, rs, alm, pw, cw, son, pot, notp;
  logic        awr, wrd, bv, arr, rvl, rga, rgw, dbw, dba, otw, ev;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdata, got;
  logic [7:0]  hb, rb, base;
  logic [15:0] rl, dl;
  logic [1:0]  bresp, rresp, resp;
  int          err_count, compares, cyc;

  afc_capture dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvl), .s_axi_rready(rre), .cmd_byte_valid(hv),
    .cmd_frame_start(hs), .cmd_byte(hb), .rsp_byte_valid(rv), .rsp_frame_start(rs),
    .rsp_byte(rb), .alarm_in(alm), .param_warning_in(pw), .command_warning_in(cw),
    .servo_on(son), .pos_overtravel_pin(pot), .neg_overtravel_pin(notp),
    .regen_level(rl), .dynamic_brake_level(dl), .regen_warning(rgw), .regen_alarm(rga),
    .dynamic_brake_warning(dbw), .dynamic_brake_alarm(dba), .overtravel_warning(otw),
    .capture_event(ev));

  afc_host_model host (.aclk(aclk), .aresetn(aresetn), .go(go), .base(base),
    .cmd_byte_valid(hv), .cmd_frame_start(hs), .cmd_byte(hb), .busy(busy));

  // ---------------------------------------------------------------
  // Clock, watchdog and closing report
  // ---------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // Bus tasks and comparisons
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit ta, tw;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bre <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awv && awr) begin
        ta = 1;
        awv <= 1'b0;
      end
      if (wv && wrd) begin
        tw = 1;
        wv <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bv);
    resp = bresp;
    bre <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    do @(posedge aclk); while (!rvl);
    got = rdata;
    resp = rresp;
    rre <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Frame and event helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] wexp(input logic [7:0] b, input int i);
    logic [7:0] x;
    x = b + 8'(4 * i);
    return {x + 8'h03, x + 8'h02, x + 8'h01, x};
  endfunction

  task automatic frames(input logic [7:0] cb, input logic [7:0] rbs);
    @(posedge aclk);
    base <= cb;
    go   <= 1'b1;
    for (int i = 0; i < 48; i++) begin
      rv <= 1'b1;
      rs <= (i == 0);
      rb <= rbs + 8'(i);
      @(posedge aclk);
      go <= 1'b0;
    end
    rv <= 1'b0;
    rs <= 1'b0;
    rb <= ~rb;
    repeat (4) @(posedge aclk);
  endtask

  task automatic chkcap(input logic [7:0] cb, input logic [7:0] rbs);
    for (int i = 0; i < 12; i++) begin
      rd(OFS_CMD_CAP + 12'(4 * i));
      chk("cmd_capture_word", wexp(cb, i), got);
      rd(OFS_RSP_CAP + 12'(4 * i));
      chk("rsp_capture_word", wexp(rbs, i), got);
    end
  endtask

  task automatic raise(input int k);
    bit seen;
    seen = 0;
    @(posedge aclk);
    if (k == 0) pw <= 1'b1;
    else if (k == 1) cw <= 1'b1;
    else alm <= 1'b1;
    repeat (4) begin
      @(posedge aclk);
      seen |= ev;
    end
    chk("capture_event", 32'h0000_0001, 32'(seen));
    pw  <= 1'b0;
    cw  <= 1'b0;
    alm <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    bit wp, wa;
    {aresetn, awv, wv, bre, arv, rre, go, rv, rs, alm, pw, cw, son, pot, notp} = '0;
    {awa, ara, wd, rb, base, rl, dl, cyc, err_count, compares} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(OFS_REGEN_WARN);
    chk("regen_warn_limit", 32'h0000_C000, got);
    rd(OFS_DB_ALARM);
    chk("db_alarm_limit", 32'h0000_FFFF, got);
    rd(OFS_STATUS);
    chk("status", 32'h0000_0000, got);
    rd(OFS_CMD_CAP);
    chk("cmd_capture_word", RST_WORD, got);
    rd(12'h100);
    chk("rresp", 32'(RESP_SLVERR), 32'(resp));
    wr(OFS_CMD_CAP, 32'hFFFF_FFFF);
    chk("bresp", 32'(RESP_SLVERR), 32'(resp));
    frames(8'h10, 8'h80);
    raise(0);
    chkcap(8'h10, 8'h80);
    rd(OFS_STATUS);
    chk("status", 32'h0000_0100, got);
    frames(8'h50, 8'hC0);
    chkcap(8'h10, 8'h80);
    raise(1);
    chkcap(8'h50, 8'hC0);
    raise(2);
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk);
      if (k == 0) rl <= 16'hFFFF;
      else dl <= 16'hFFFF;
      wp = 0;
      wa = 0;
      for (int n = 0; n < 20 && !wa; n++) begin
        @(posedge aclk);
        wa = k ? dba : rga;
        if (wa) chk("warning_before_alarm", 32'h0000_0001, 32'(wp));
        wp = k ? dbw : rgw;
      end
      chk("overload_alarm", 32'h0000_0001, 32'(wa));
    end
    rl <= 16'h0000;
    dl <= 16'h0000;
    rd(OFS_STATUS);
    chk("status_flags", 32'h0000_000F, got & 32'h0000_00FF);
    wr(OFS_CTRL, 32'h0000_0001);
    rd(OFS_STATUS);
    chk("status_flags", 32'h0000_0000, got & 32'h0000_00FF);
    son <= 1'b1;
    pot <= 1'b1;
    repeat (5) @(posedge aclk);
    pot <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("overtravel_warning", 32'h0000_0001, 32'(otw));
    wr(OFS_CTRL, 32'h0000_0001);
    son  <= 1'b0;
    notp <= 1'b1;
    repeat (5) @(posedge aclk);
    notp <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("overtravel_warning", 32'h0000_0000, 32'(otw));
    end_of_test();
  end
endmodule
`default_nettype wire
